// ==== rtl/prsc_pkg.sv ====
// Constants for the policer and router-leg statistics counter block
package prsc_pkg;
   localparam int NUM_SETS = 5;
   localparam int SET_BUNDLE = 0;
   localparam int SET_BCAST = 1;
   localparam int SET_ACL = 2;
   localparam int SET_INGRESS = 3;
   localparam int SET_EGRESS = 4;
   localparam int MAX_POS = 8;
   localparam int CNT_W = 40;
   localparam int LOW_W = 32;
   localparam int HIGH_W = 8;
   localparam int LEN_W = 14;
   localparam int MASK_W = 8;
   localparam int IDX_W = 7;
   localparam int ADDR_W = 12;
   localparam int ROUTER_LEG_TOTAL = 64;
   localparam int IP_VERSIONS = 2;
   localparam int BUNDLE_POLICER_COUNT = 8;
   localparam int BCAST_POLICER_COUNT = 8;
   localparam int ACL_POLICER_COUNT = 8;
   localparam int LEG_SETS = ROUTER_LEG_TOTAL * IP_VERSIONS;
   localparam int SET_NPOS[NUM_SETS] = '{2, 2, 2, 8, 8};
   localparam int SET_NIDX[NUM_SETS] = '{BUNDLE_POLICER_COUNT,
      BCAST_POLICER_COUNT, ACL_POLICER_COUNT, LEG_SETS, LEG_SETS};
   localparam int SET_BASE[NUM_SETS] = '{0, 16, 32, 48, 1072};
   localparam int TOTAL_CNT = 2096;
   // Configuration word per set and position: index set*8+pos
   localparam logic [15:0] CFG_BASE = 16'h0000;
   localparam int CFG_BYTES_BIT = 0;
   localparam int CFG_MASK_LSB = 8;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   // Counter region: counter n low word at base+8n, high part at +4
   localparam logic [15:0] CNT_REGION = 16'h8000;
   localparam logic [15:0] BUNDLE_POLICER_COUNT_LOW = 16'h8000;
   localparam logic [15:0] BUNDLE_POLICER_COUNT_HIGH = 16'h8004;
   localparam logic [15:0] BCAST_POLICER_COUNT_LOW = 16'h8080;
   localparam logic [15:0] BCAST_POLICER_COUNT_HIGH = 16'h8084;
   localparam logic [15:0] ACCESS_LIST_POLICER_COUNT_LOW = 16'h8100;
   localparam logic [15:0] ACCESS_LIST_POLICER_COUNT_HIGH = 16'h8104;
   localparam logic [15:0] INGRESS_LEG_COUNT_LOW = 16'h8180;
   localparam logic [15:0] INGRESS_LEG_COUNT_HIGH = 16'h8184;
   localparam logic [15:0] EGRESS_LEG_COUNT_LOW = 16'hA180;
   localparam logic [15:0] EGRESS_LEG_COUNT_HIGH = 16'hA184;
   localparam int HIGH_SEL_BIT = 2;
   localparam logic [39:0] CNT_RESET = 40'h00_0000_0000;
endpackage : prsc_pkg

// ==== rtl/prsc_stat_counters.sv ====
// Policer and router-leg statistics counters with an APB register slave
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module prsc_stat_counters (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bundle dual-bucket policer events
   input wire logic bndl_ev_valid,
   input wire logic [2:0] bndl_ev_index,
   input wire logic [2:0] bndl_ev_color,
   input wire logic [13:0] bndl_ev_len,
   // Broadcast/unicast/multicast policer events
   input wire logic bcast_ev_valid,
   input wire logic [2:0] bcast_ev_index,
   input wire logic [5:0] bcast_ev_event,
   input wire logic [13:0] bcast_ev_len,
   // Access-list policer events
   input wire logic acl_ev_valid,
   input wire logic [2:0] acl_ev_index,
   input wire logic acl_inner_access_list_flag,
   input wire logic acl_ev_from_cpu,
   input wire logic acl_ev_discarded,
   input wire logic [13:0] acl_ev_len,
   // Ingress router leg events
   input wire logic ingress_router_leg_valid,
   input wire logic [5:0] ingress_router_leg_index,
   input wire logic ingress_router_leg_ipv6,
   input wire logic [6:0] ingress_router_leg_event,
   input wire logic [13:0] ingress_router_leg_len,
   // Egress router leg events
   input wire logic egress_router_leg_valid,
   input wire logic [5:0] egress_router_leg_index,
   input wire logic egress_router_leg_ipv6,
   input wire logic [4:0] egress_router_leg_event,
   input wire logic [13:0] egress_router_leg_len
);

   logic [39:0] cnt [prsc_pkg::TOTAL_CNT];
   logic count_bytes_select [prsc_pkg::NUM_SETS][prsc_pkg::MAX_POS];
   logic [7:0] ev_mask [prsc_pkg::NUM_SETS][prsc_pkg::MAX_POS];
   logic [7:0] shadow_high;
   logic [7:0] pend_high;

   logic ev_valid [prsc_pkg::NUM_SETS];
   logic [6:0] ev_idx [prsc_pkg::NUM_SETS];
   logic [7:0] ev_evt [prsc_pkg::NUM_SETS];
   logic [13:0] ev_len [prsc_pkg::NUM_SETS];
   logic [2:0] acl_evt_sel;

   logic acc_first;
   logic acc_done;
   logic is_cfg;
   logic is_cnt;
   logic cfg_hit;
   logic cnt_hit;
   logic [2:0] cfg_set;
   logic [2:0] cfg_pos;
   logic [11:0] cnt_addr;
   logic high_sel;
   logic [31:0] next_prdata;
   logic next_err;

   // Gather event sources into uniform per-set arrays
   always_comb begin
      acl_evt_sel = {acl_inner_access_list_flag, acl_ev_discarded,
         ~acl_ev_from_cpu};
      ev_valid[prsc_pkg::SET_BUNDLE] = bndl_ev_valid;
      ev_idx[prsc_pkg::SET_BUNDLE] = {4'h0, bndl_ev_index};
      ev_evt[prsc_pkg::SET_BUNDLE] = {5'h00, bndl_ev_color};
      ev_len[prsc_pkg::SET_BUNDLE] = bndl_ev_len;
      ev_valid[prsc_pkg::SET_BCAST] = bcast_ev_valid;
      ev_idx[prsc_pkg::SET_BCAST] = {4'h0, bcast_ev_index};
      ev_evt[prsc_pkg::SET_BCAST] = {2'h0, bcast_ev_event};
      ev_len[prsc_pkg::SET_BCAST] = bcast_ev_len;
      ev_valid[prsc_pkg::SET_ACL] = acl_ev_valid;
      ev_idx[prsc_pkg::SET_ACL] = {4'h0, acl_ev_index};
      ev_evt[prsc_pkg::SET_ACL] = 8'h01 << acl_evt_sel;
      ev_len[prsc_pkg::SET_ACL] = acl_ev_len;
      ev_valid[prsc_pkg::SET_INGRESS] = ingress_router_leg_valid;
      ev_idx[prsc_pkg::SET_INGRESS] = {ingress_router_leg_ipv6,
         ingress_router_leg_index};
      ev_evt[prsc_pkg::SET_INGRESS] = {1'h0, ingress_router_leg_event};
      ev_len[prsc_pkg::SET_INGRESS] = ingress_router_leg_len;
      ev_valid[prsc_pkg::SET_EGRESS] = egress_router_leg_valid;
      ev_idx[prsc_pkg::SET_EGRESS] = {egress_router_leg_ipv6,
         egress_router_leg_index};
      ev_evt[prsc_pkg::SET_EGRESS] = {3'h0, egress_router_leg_event};
      ev_len[prsc_pkg::SET_EGRESS] = egress_router_leg_len;
   end

   // APB phase and address decode
   assign acc_first = psel && penable && !pready;
   assign acc_done = psel && penable && pready;
   assign is_cfg = (paddr[15:8] == prsc_pkg::CFG_BASE[15:8]);
   assign is_cnt = paddr[15] == prsc_pkg::CNT_REGION[15];
   assign cfg_set = paddr[7:5];
   assign cfg_pos = paddr[4:2];
   assign cnt_addr = paddr[14:3];
   assign high_sel = paddr[prsc_pkg::HIGH_SEL_BIT];
   assign cfg_hit = is_cfg && (paddr[1:0] == 2'h0)
      && (int'(cfg_set) < prsc_pkg::NUM_SETS)
      && (int'(cfg_pos) < prsc_pkg::SET_NPOS[cfg_set]);
   assign cnt_hit = is_cnt && (paddr[1:0] == 2'h0)
      && (int'(cnt_addr) < prsc_pkg::TOTAL_CNT);

   // Read data for the access being served
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_err = 1'b0;
      if (cfg_hit) begin
         next_prdata[prsc_pkg::CFG_BYTES_BIT] =
            count_bytes_select[cfg_set][cfg_pos];
         next_prdata[prsc_pkg::CFG_MASK_LSB +: 8] = ev_mask[cfg_set][cfg_pos];
      end else if (cnt_hit) begin
         if (high_sel) begin
            next_prdata = {24'h00_0000, shadow_high};
         end else begin
            next_prdata = cnt[cnt_addr][31:0];
         end
      end else begin
         next_err = 1'b1;
      end
   end

   // One wait state, then the answer
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc_first;
         if (acc_first) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
            pslverr <= next_err;
         end else begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // Shadow capture on low-word read, pending high on high-part write
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         shadow_high <= 8'h00;
         pend_high <= 8'h00;
      end else begin
         if (acc_first && !pwrite && cnt_hit && !high_sel) begin
            shadow_high <= cnt[cnt_addr][39:32];
         end
         if (acc_done && pwrite && cnt_hit && high_sel) begin
            pend_high <= pwdata[7:0];
         end
      end
   end

   // Per-set, per-position byte mode and event mask, shared by all indices of a set
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int s = 0; s < prsc_pkg::NUM_SETS; s++) begin
            for (int p = 0; p < prsc_pkg::MAX_POS; p++) begin
               count_bytes_select[s][p] <=
                  prsc_pkg::CFG_RESET[prsc_pkg::CFG_BYTES_BIT];
               ev_mask[s][p] <= prsc_pkg::CFG_RESET[15:8];
            end
         end
      end else if (acc_done && pwrite && cfg_hit) begin
         count_bytes_select[cfg_set][cfg_pos] <=
            pwdata[prsc_pkg::CFG_BYTES_BIT];
         ev_mask[cfg_set][cfg_pos] <=
            pwdata[prsc_pkg::CFG_MASK_LSB +: 8];
      end
   end

   // Counter array: event increments, then software writes take priority
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < prsc_pkg::TOTAL_CNT; i++) begin
            cnt[i] <= prsc_pkg::CNT_RESET;
         end
      end else begin
         for (int s = 0; s < prsc_pkg::NUM_SETS; s++) begin
            for (int p = 0; p < prsc_pkg::MAX_POS; p++) begin
               if (p < prsc_pkg::SET_NPOS[s] && ev_valid[s]
                  && int'(ev_idx[s]) < prsc_pkg::SET_NIDX[s]
                  && |(ev_evt[s] & ev_mask[s][p])) begin
                  cnt[prsc_pkg::SET_BASE[s]
                     + int'(ev_idx[s]) * prsc_pkg::SET_NPOS[s] + p] <=
                     cnt[prsc_pkg::SET_BASE[s]
                     + int'(ev_idx[s]) * prsc_pkg::SET_NPOS[s] + p]
                     + (count_bytes_select[s][p] ? {26'h000_0000, ev_len[s]}
                     : 40'h00_0000_0001);
               end
            end
         end
         if (acc_done && pwrite && cnt_hit && !high_sel) begin
            cnt[cnt_addr] <= {pend_high, pwdata};
         end
      end
   end

endmodule : prsc_stat_counters

// ==== dv/prsc_stat_counters_asserts.sv ====
// Port checker for the statistics counter block
`timescale 1ns/1ps
module prsc_sc_asserts (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   property p_one_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("late ready");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("long ready");
   property p_cause;
      pready |-> $past(psel && penable);
   endproperty
   a_cause: assert property (p_cause) else $error("stray ready");
   property p_misal;
      psel && penable && !pready && paddr[1:0] != 2'h0 |=> pslverr;
   endproperty
   a_misal: assert property (p_misal) else $error("no error");
   property p_err_zero;
      pslverr |-> pready && prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("bad error");
   property p_idle;
      !pready |-> prdata == 32'h0;
   endproperty
   a_idle: assert property (p_idle) else $error("idle data");
   property p_high;
      pready && !pwrite && paddr[15] && paddr[2] |-> prdata[31:8] == 24'h0;
   endproperty
   a_high: assert property (p_high) else $error("wide high");
   property p_cfg;
      pready && !pwrite && !paddr[15] |-> prdata[31:16] == 16'h0
         && prdata[7:1] == 7'h0;
   endproperty
   a_cfg: assert property (p_cfg) else $error("cfg bits");
   property p_map;
      pready && paddr[15] && paddr[1:0] == 2'h0 && paddr < 16'hC180
         |-> !pslverr;
   endproperty
   a_map: assert property (p_map) else $error("counter refused");
endmodule : prsc_sc_asserts
bind prsc_stat_counters prsc_sc_asserts u_chk (.clk_sys(clk_sys),
   .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== dv/test_prsc_stat_counters.sv ====
// Self-checking bench for the statistics counter block
`timescale 1ns/1ps
module test_prsc_stat_counters;
   logic clk_sys = 0;
   logic resetn = 0;
   logic psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, r;
   logic pready, pslverr, e;
   logic bv = 0, cv = 0, av = 0, iv = 0, ev = 0;
   logic [2:0] bi = 0, bc = 0, ci = 0, ai = 0;
   logic [5:0] ce = 0, ii = 0, ei = 0;
   logic [6:0] ie = 0;
   logic [4:0] ee = 0;
   logic [13:0] bl = 0, cl = 0, al = 0, il = 0, el = 0;
   logic afl = 0, acpu = 0, adis = 0, i6 = 0, e6 = 0;
   logic [39:0] v;
   int errors = 0;
   int n_tests = 0;
   always #5 clk_sys = ~clk_sys;
   prsc_stat_counters dut_u (.clk_sys(clk_sys), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bndl_ev_valid(bv), .bndl_ev_index(bi), .bndl_ev_color(bc),
      .bndl_ev_len(bl), .bcast_ev_valid(cv), .bcast_ev_index(ci),
      .bcast_ev_event(ce), .bcast_ev_len(cl), .acl_ev_valid(av),
      .acl_ev_index(ai), .acl_inner_access_list_flag(afl),
      .acl_ev_from_cpu(acpu), .acl_ev_discarded(adis), .acl_ev_len(al),
      .ingress_router_leg_valid(iv), .ingress_router_leg_index(ii),
      .ingress_router_leg_ipv6(i6), .ingress_router_leg_event(ie),
      .ingress_router_leg_len(il), .egress_router_leg_valid(ev),
      .egress_router_leg_index(ei), .egress_router_leg_ipv6(e6),
      .egress_router_leg_event(ee), .egress_router_leg_len(el));
   task chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task rd40(input int n);
      apb(0, 16'h8000 + 16'(n * 8), 0);
      v[31:0] = r;
      apb(0, 16'h8004 + 16'(n * 8), 0);
      v[39:32] = r[7:0];
   endtask : rd40
   task cfg(input int s, input int p, input logic [31:0] d);
      apb(1, 16'((s * 8 + p) * 4), d);
   endtask : cfg
   task fire;
      @(posedge clk_sys);
      bv <= 0;
      cv <= 0;
      av <= 0;
      iv <= 0;
      ev <= 0;
      @(posedge clk_sys);
   endtask : fire
   task s_bundle;
      cfg(0, 0, 32'h0000_0101);
      cfg(0, 1, 32'h0000_0600);
      bv <= 1;
      bi <= 3'h3;
      bc <= 3'h1;
      bl <= 14'h0064;
      fire;
      bv <= 1;
      bc <= 3'h4;
      fire;
      bv <= 1;
      bc <= 3'h2;
      fire;
      rd40(6);
      chk(v, 40'h64);
      rd40(7);
      chk(v, 40'h2);
   endtask : s_bundle
   task s_bcast;
      for (int b = 0; b < 6; b++) begin
         cfg(1, 0, 32'h1 << (b + 8));
         cv <= 1;
         ci <= 3'h5;
         cl <= 14'h0009;
         ce <= 6'(1 << ((b + 1) % 6));
         fire;
         cv <= 1;
         ce <= 6'(1 << b);
         fire;
      end
      rd40(26);
      chk(v, 40'h6);
      rd40(27);
      chk(v, 40'h0);
   endtask : s_bcast
   task s_acl;
      for (int k = 0; k < 8; k++) begin
         cfg(2, 1, (32'h1 << (k + 8)) | 32'h1);
         av <= 1;
         ai <= 3'h7;
         al <= 14'h0003;
         afl <= k[2];
         adis <= k[1];
         acpu <= !k[0];
         fire;
         av <= 1;
         afl <= !k[2];
         fire;
      end
      rd40(47);
      chk(v, 40'h18);
   endtask : s_acl
   task s_legs;
      cfg(3, 7, 32'h0000_4001);
      cfg(4, 0, 32'h0000_1000);
      iv <= 1;
      ii <= 6'h3F;
      i6 <= 1;
      ie <= 7'h40;
      il <= 14'h3FFF;
      ev <= 1;
      ee <= 5'h10;
      fire;
      iv <= 1;
      ie <= 7'h3F;
      ev <= 1;
      ee <= 5'h0F;
      fire;
      ev <= 1;
      e6 <= 1;
      ei <= 6'h01;
      ee <= 5'h10;
      fire;
      rd40(1071);
      chk(v, 40'h3FFF);
      rd40(559);
      chk(v, 40'h0);
      rd40(1072);
      chk(v, 40'h1);
      rd40(1592);
      chk(v, 40'h1);
      apb(0, prsc_pkg::EGRESS_LEG_COUNT_LOW, 0);
      chk(r, 40'h1);
   endtask : s_legs
   task s_wide;
      apb(1, 16'h8004, 32'h0000_00FF);
      rd40(0);
      chk(v, 40'h0);
      apb(1, 16'h8000, 32'hFFFF_FFF0);
      apb(0, 16'h8000, 0);
      chk(r, 40'hFFFF_FFF0);
      bv <= 1;
      bi <= 3'h0;
      bc <= 3'h1;
      bl <= 14'h0020;
      fire;
      apb(0, 16'h8004, 0);
      chk(r, 40'hFF);
      rd40(0);
      chk(v, 40'h10);
   endtask : s_wide
   task s_err;
      apb(0, 16'h0002, 0);
      chk({e, r}, {1'b1, 32'h0});
      apb(1, 16'hFFF0, 32'h0000_00A5);
      chk(e, 1'b1);
   endtask : s_err
   task final_report;
      if (errors == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1;
      rd40(6);
      chk(v, 40'h0);
      s_bundle;
      s_bcast;
      s_acl;
      s_legs;
      s_wide;
      s_err;
      final_report;
   end
   initial begin
      #100us;
      errors++;
      final_report;
   end
endmodule : test_prsc_stat_counters
